// *** core/sac_consts.vh ***
// constants shared by the sar converter control logic
// assumes inclusion by bare name from files under core/
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// start-of-conversion source codes
`define SAC_SRC_SOFTWARE  3'h0
`define SAC_SRC_TIMER0    3'h1
`define SAC_SRC_TIMER2    3'h2
`define SAC_SRC_TIMER1    3'h3
`define SAC_SRC_EXT_PIN   3'h4
`define SAC_SRC_TIMER3    3'h5

// input mux codes
`define SAC_POS_TEMP      5'h1E
`define SAC_POS_SUPPLY    5'h1F
`define SAC_POS_RSV_LO    5'h15
`define SAC_POS_RSV_HI    5'h1D
`define SAC_NEG_GND       5'h1F

// conversion figures
`define SAC_TRACK_CLOCKS  2'h3
`define SAC_MSB_INDEX     4'h9
`define SAC_CODE_MSB      10'h200
`define SAC_CODE_ZERO     10'h000
`define SAC_LJ_PAD        6'h00
`define SAC_RESULT_ZERO   16'h0000

`endif

// *** core/sac_top.v ***
// sar converter conversion control: start selection, tracking, bit sequencing, formatting
// assumes all inputs are synchronous to clk and timer overflows are one-cycle pulses;
// the analog array answers sar_compare for the current trial code within a sar clock
`timescale 1ns/100ps
`default_nettype none
`include "sac_consts.vh"

module sac_top #(
  parameter RES_BITS = 10
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // control bits
  input  wire        converter_enable,
  input  wire        left_align_select,
  input  wire        low_power_track_select,
  input  wire [2:0]  start_source_select,
  input  wire [4:0]  sar_clock_divisor,
  input  wire [4:0]  positive_input_select,
  input  wire [4:0]  negative_input_select,
  input  wire        busy_write_one,
  input  wire        done_flag_clear,
  input  wire        done_irq_enable,
  // start sources
  input  wire        timer0_overflow,
  input  wire        timer1_overflow,
  input  wire        timer2_low_overflow,
  input  wire        timer2_high_overflow,
  input  wire        timer2_16bit_mode,
  input  wire        timer3_low_overflow,
  input  wire        timer3_high_overflow,
  input  wire        timer3_16bit_mode,
  input  wire        external_convert_start,
  // analog array
  input  wire        sar_compare,
  output reg  [9:0]  sar_trial_code,
  output reg         analog_powered,
  output reg         track_enable,
  output reg         single_ended_mode,
  output reg  [4:0]  mux_positive_code,
  output reg  [4:0]  mux_negative_code,
  output reg         mux_positive_temp,
  output reg         mux_positive_supply,
  output reg         mux_positive_reserved,
  output reg         sar_clock_tick,
  // status and result
  output reg         conversion_in_progress,
  output reg         conversion_done_flag,
  output wire        conversion_irq,
  output reg  [7:0]  result_high_byte,
  output reg  [7:0]  result_low_byte
);

  // ************************************************************
  // reset release
  // ************************************************************
  reg        rst_meta_r;
  reg        rst_sync_r;

  // reset asserts at once but leaves on a clock edge, so no register
  // sees a release that lands close to the clock

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  wire       rst_int_n = rst_sync_r;

  // ************************************************************
  // states and storage
  // ************************************************************
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_TRACK = 2'h1;
  localparam [1:0] ST_CONV  = 2'h2;

  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg [4:0]  div_cnt_r;
  reg [4:0]  div_cnt_nxt;
  reg [1:0]  track_cnt_r;
  reg [1:0]  track_cnt_nxt;
  reg [3:0]  bit_idx_r;
  reg [3:0]  bit_idx_nxt;
  reg [9:0]  code_nxt;
  reg        pin_prev_r;
  reg        busy_nxt;
  reg        done_nxt;
  reg        finish;
  reg [9:0]  bit_mask;
  reg [9:0]  final_code;
  reg [9:0]  signed_code;
  reg [15:0] result_word;

  // ************************************************************
  // sar clock divider
  // ************************************************************
  // divider is held at zero while the sequencer is idle so the first
  // tracking or bit period is always a full sar clock long
  // a divisor lowered below the running count makes that one period run
  // through the full 5-bit wrap; change it only between conversions
  wire       div_wrap = (div_cnt_r == sar_clock_divisor);

  always @* begin
    div_cnt_nxt = div_cnt_r + 5'h01;
    if (!converter_enable || div_wrap) begin
      div_cnt_nxt = 5'h00;
    end
    if (state_r == ST_IDLE) begin
      div_cnt_nxt = 5'h00;
    end
  end

  wire       sar_tick = converter_enable && (state_r != ST_IDLE) && div_wrap;

  // ************************************************************
  // start selection
  // ************************************************************
  // pin history updates in every state, so a pin held high through a
  // conversion cannot start another one once the sequencer is idle again
  wire       pin_rise  = external_convert_start && !pin_prev_r;
  wire       t2_ovf    = timer2_16bit_mode ? timer2_high_overflow : timer2_low_overflow;
  wire       t3_ovf    = timer3_16bit_mode ? timer3_high_overflow : timer3_low_overflow;
  reg        start_evt;

  always @* begin
    start_evt = 1'b0;
    case (start_source_select)
      `SAC_SRC_SOFTWARE: start_evt = busy_write_one;
      `SAC_SRC_TIMER0:   start_evt = timer0_overflow;
      `SAC_SRC_TIMER1:   start_evt = timer1_overflow;
      `SAC_SRC_TIMER2:   start_evt = t2_ovf;
      `SAC_SRC_TIMER3:   start_evt = t3_ovf;
      `SAC_SRC_EXT_PIN:  start_evt = pin_rise;
      // codes 6 and 7 select no source: the converter stays enabled but idle
      default:           start_evt = 1'b0;
    endcase
  end

  wire       ext_src = (start_source_select == `SAC_SRC_EXT_PIN);

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  always @* begin
    state_nxt     = state_r;
    track_cnt_nxt = track_cnt_r;
    bit_idx_nxt   = bit_idx_r;
    code_nxt      = sar_trial_code;
    busy_nxt      = conversion_in_progress;
    finish        = 1'b0;
    bit_mask      = `SAC_CODE_MSB >> (`SAC_MSB_INDEX - bit_idx_r);
    case (state_r)
      ST_IDLE: begin
        // a start is only looked at here, so one during a conversion is dropped
        if (converter_enable && start_evt) begin
          busy_nxt = 1'b1;
          if (low_power_track_select && !ext_src) begin
            state_nxt     = ST_TRACK;
            track_cnt_nxt = 2'h0;
          end else begin
            // pin source in low-power mode has already tracked while the pin was low
            state_nxt   = ST_CONV;
            bit_idx_nxt = `SAC_MSB_INDEX;
            code_nxt    = `SAC_CODE_MSB;
          end
        end
      end
      ST_TRACK: begin
        if (sar_tick) begin
          track_cnt_nxt = track_cnt_r + 2'h1;
          if (track_cnt_r == (`SAC_TRACK_CLOCKS - 2'h1)) begin
            state_nxt   = ST_CONV;
            bit_idx_nxt = `SAC_MSB_INDEX;
            code_nxt    = `SAC_CODE_MSB;
          end
        end
      end
      ST_CONV: begin
        if (sar_tick) begin
          // keep or drop the trial bit, msb first
          if (!sar_compare) begin
            code_nxt = sar_trial_code & ~bit_mask;
          end
          if (bit_idx_r == 4'h0) begin
            state_nxt = ST_IDLE;
            busy_nxt  = 1'b0;
            finish    = 1'b1;
          end else begin
            bit_idx_nxt = bit_idx_r - 4'h1;
            code_nxt    = code_nxt | (bit_mask >> 1);
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase
    // disable overrides everything: an aborted conversion drops busy, leaves
    // the done flag alone and keeps the old result bytes
    if (!converter_enable) begin
      state_nxt = ST_IDLE;
      busy_nxt  = 1'b0;
      code_nxt  = `SAC_CODE_ZERO;
    end
  end

  // ************************************************************
  // result formatting
  // ************************************************************
  // formatting reads the code as it stands after this edge, so the finish
  // cycle stores the last bit decision without an extra clock
  wire       diff_mode = (negative_input_select != `SAC_NEG_GND);

  always @* begin
    final_code  = code_nxt;
    // the array counts offset binary; flipping the msb gives two's complement
    signed_code = final_code ^ `SAC_CODE_MSB;
    result_word = `SAC_RESULT_ZERO;
    if (!diff_mode) begin
      if (left_align_select) begin
        result_word = {final_code, `SAC_LJ_PAD};
      end else begin
        result_word = {6'h00, final_code};
      end
    end else begin
      if (left_align_select) begin
        result_word = {signed_code, `SAC_LJ_PAD};
      end else begin
        result_word = {{6{signed_code[9]}}, signed_code};
      end
    end
  end

  // ************************************************************
  // done flag
  // ************************************************************
  always @* begin
    done_nxt = conversion_done_flag;
    if (done_flag_clear) begin
      done_nxt = 1'b0;
    end
    // falling busy wins over a clear in the same cycle
    if (conversion_in_progress && !busy_nxt && finish) begin
      done_nxt = 1'b1;
    end
  end

  assign conversion_irq = conversion_done_flag && done_irq_enable;

  // ************************************************************
  // registers
  // ************************************************************
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_r                <= ST_IDLE;
      div_cnt_r              <= 5'h00;
      track_cnt_r            <= 2'h0;
      bit_idx_r              <= 4'h0;
      pin_prev_r             <= 1'b0;
      sar_trial_code         <= `SAC_CODE_ZERO;
      conversion_in_progress <= 1'b0;
      conversion_done_flag   <= 1'b0;
      sar_clock_tick         <= 1'b0;
    end else begin
      state_r                <= state_nxt;
      div_cnt_r              <= div_cnt_nxt;
      track_cnt_r            <= track_cnt_nxt;
      bit_idx_r              <= bit_idx_nxt;
      pin_prev_r             <= external_convert_start;
      sar_trial_code         <= code_nxt;
      conversion_in_progress <= busy_nxt;
      conversion_done_flag   <= done_nxt;
      sar_clock_tick         <= sar_tick;
    end
  end

  // ************************************************************
  // result bytes
  // ************************************************************
  // both bytes move together in the finish cycle only, so a read between
  // conversions never mixes two results
  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      result_high_byte <= 8'h00;
      result_low_byte  <= 8'h00;
    end else if (finish) begin
      result_high_byte <= result_word[15:8];
      result_low_byte  <= result_word[7:0];
    end
  end

  // ************************************************************
  // analog front-end controls
  // ************************************************************
  // low-power pin mode is the one low-power case where tracking comes before the
  // start event instead of after it
  reg        track_nxt;

  always @* begin
    track_nxt = 1'b0;
    if (converter_enable) begin
      if (!low_power_track_select) begin
        track_nxt = (state_nxt != ST_CONV);
      end else if (ext_src) begin
        track_nxt = (state_nxt == ST_IDLE) && !external_convert_start;
      end else begin
        track_nxt = (state_nxt == ST_TRACK);
      end
    end
  end

  always @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      analog_powered        <= 1'b0;
      track_enable          <= 1'b0;
      single_ended_mode     <= 1'b1;
      mux_positive_code     <= 5'h00;
      mux_negative_code     <= 5'h00;
      mux_positive_temp     <= 1'b0;
      mux_positive_supply   <= 1'b0;
      mux_positive_reserved <= 1'b0;
    end else begin
      analog_powered        <= converter_enable;
      track_enable          <= track_nxt;
      single_ended_mode     <= !diff_mode;
      mux_positive_code     <= positive_input_select;
      mux_negative_code     <= negative_input_select;
      mux_positive_temp     <= (positive_input_select == `SAC_POS_TEMP);
      mux_positive_supply   <= (positive_input_select == `SAC_POS_SUPPLY);
      mux_positive_reserved <= (positive_input_select >= `SAC_POS_RSV_LO) &&
                               (positive_input_select <= `SAC_POS_RSV_HI);
    end
  end

endmodule
`default_nettype wire

// *** sim/sac_monitor.sv ***
// checker for the sar converter control, bound into sac_top
// sees only top-level ports; single clock domain
`timescale 1ns/100ps
`default_nettype none
module sac_monitor #(
  parameter RES_BITS = 10
) (
  // clock, reset, controls
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       converter_enable,
  input wire logic       low_power_track_select,
  input wire logic [2:0] start_source_select,
  input wire logic [4:0] sar_clock_divisor,
  input wire logic [4:0] positive_input_select,
  input wire logic [4:0] negative_input_select,
  input wire logic       done_irq_enable,
  // observed outputs
  input wire logic [9:0] sar_trial_code,
  input wire logic       track_enable,
  input wire logic       single_ended_mode,
  input wire logic       mux_positive_temp,
  input wire logic       mux_positive_reserved,
  input wire logic       conversion_in_progress,
  input wire logic       conversion_done_flag,
  input wire logic       conversion_irq,
  input wire logic [7:0] result_high_byte,
  input wire logic [7:0] result_low_byte
);
  // ****************
  // helpers
  // ****************
  // internal reset lags rst_n by two edges, so checks wait three
  logic [1:0] up_r;
  logic [9:0] len_r;
  wire        up = (up_r == 2'h3);
  wire  [9:0] per = {5'h00, sar_clock_divisor} + 10'h001;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_r  <= 2'h0;
      len_r <= 10'h000;
    end else begin
      up_r  <= up ? up_r : up_r + 2'h1;
      len_r <= conversion_in_progress ? len_r + 10'h001 : 10'h000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************
  // properties
  // ****************
  property p_mode;
    up |=> single_ended_mode == ($past(negative_input_select) == 5'h1F);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_temp;
    up |=> mux_positive_temp == ($past(positive_input_select) == 5'h1E);
  endproperty
  a_temp: assert property (p_temp) else $error("sensor decode wrong");
  property p_rsv;
    up |=> mux_positive_reserved == ($past(positive_input_select) inside {[5'h15:5'h1D]});
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved decode wrong");
  property p_done;
    up && $fell(conversion_in_progress) && $past(converter_enable) |-> conversion_done_flag;
  endproperty
  a_done: assert property (p_done) else $error("done flag not set");
  property p_irq;
    up |-> conversion_irq == (conversion_done_flag && done_irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_off;
    up && !converter_enable |=> !conversion_in_progress && sar_trial_code == 10'h000;
  endproperty
  a_off: assert property (p_off) else $error("active while disabled");
  property p_res;
    up && ($changed(result_high_byte) || $changed(result_low_byte))
      |-> $fell(conversion_in_progress);
  endproperty
  a_res: assert property (p_res) else $error("result moved off finish");
  // low-power tracking adds three sar clocks unless the pin starts it
  property p_len;
    up && $fell(conversion_in_progress) && $past(converter_enable) |-> len_r ==
      $past(per) * (($past(low_power_track_select) && $past(start_source_select) != 3'h4)
      ? RES_BITS + 3 : RES_BITS);
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_track;
    up && $past(converter_enable) && !$past(low_power_track_select, 1)
      |-> track_enable == !conversion_in_progress;
  endproperty
  a_track: assert property (p_track) else $error("tracking wrong");
endmodule
bind sac_top sac_monitor #(.RES_BITS(RES_BITS)) i_sac_monitor (.*);
`default_nettype wire

// *** sim/sac_array_model.sv ***
// behavioural analog array for the sar sequencer
// answers at once for the trial code; held_code is the sampled input
`timescale 1ns/100ps
`default_nettype none
module sac_array_model (
  // sar side
  input  wire logic [9:0] sar_trial_code,
  input  wire logic [9:0] held_code,
  output var  logic       sar_compare
);
  // keep the trial bit while the trial code does not overshoot the sample
  always_comb sar_compare = (sar_trial_code <= held_code);
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for sac_top with the array model
// assumes sac_monitor is bound by its own file
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, rst_n, converter_enable, left_align_select, low_power_track_select;
  logic busy_write_one, done_flag_clear, done_irq_enable, sar_compare;
  logic timer0_overflow, timer1_overflow, timer2_low_overflow, timer2_high_overflow;
  logic timer2_16bit_mode, timer3_low_overflow, timer3_high_overflow, timer3_16bit_mode;
  logic external_convert_start, analog_powered, track_enable, single_ended_mode;
  logic mux_positive_temp, mux_positive_supply, mux_positive_reserved, sar_clock_tick;
  logic conversion_in_progress, conversion_done_flag, conversion_irq;
  logic [2:0]  start_source_select;
  logic [4:0]  sar_clock_divisor, positive_input_select, negative_input_select;
  logic [4:0]  mux_positive_code, mux_negative_code;
  logic [9:0]  sar_trial_code, held_code, code;
  logic [7:0]  result_high_byte, result_low_byte;
  logic [31:0] seed, r;
  integer      mismatches, num_checks, i;
  sac_top i_sac_top (.*);
  sac_array_model i_sac_array_model (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****************
  // helpers
  // ****************
  function automatic [31:0] rnd;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  // array is offset binary; the signed view is code minus half scale
  function automatic [15:0] want(input [9:0] c, input se, input lj);
    integer v;
    begin
      v = se ? c : c - 512;
      if (lj) v = v * 64;
      want = v[15:0];
    end
  endfunction
  task automatic chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task automatic finish_test;
    begin
      if (mismatches == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task automatic fire(input [2:0] s, input wrong);
    begin
      @(posedge clk);
      // the bench alone drives the start pin, as for a pin the crossbar skips
      case (s)
        3'h1: timer0_overflow <= 1'b1;
        3'h3: timer1_overflow <= 1'b1;
        3'h2: if (timer2_16bit_mode ^ wrong) timer2_high_overflow <= 1'b1;
              else timer2_low_overflow <= 1'b1;
        3'h5: if (timer3_16bit_mode ^ wrong) timer3_high_overflow <= 1'b1;
              else timer3_low_overflow <= 1'b1;
        3'h4: external_convert_start <= 1'b1;
        default: busy_write_one <= 1'b1;
      endcase
      @(posedge clk);
      {busy_write_one, timer0_overflow, timer1_overflow} <= 3'h0;
      {timer2_low_overflow, timer2_high_overflow} <= 2'h0;
      {timer3_low_overflow, timer3_high_overflow} <= 2'h0;
      #1;
    end
  endtask
  // stray starts are thrown in mid-conversion and must change nothing
  task automatic conv(input [2:0] s);
    integer n, t;
    begin
      if (s == 3'h2 || s == 3'h5) begin
        fire(s, 1'b1);
        chk(16'(conversion_in_progress), 16'h0000);
      end
      fire(s, 1'b0);
      chk(16'(conversion_in_progress), 16'h0001);
      n = 0;
      t = 0;
      // the result bytes are trusted only once the done flag reads 1
      while (conversion_done_flag !== 1'b1 && n < 600) begin
        @(posedge clk);
        busy_write_one <= (n == 3);
        timer0_overflow <= (n == 3);
        #1;
        t = t + sar_clock_tick;
        n = n + 1;
      end
      chk(16'(t), (low_power_track_select && s != 3'h4) ? 16'h000D : 16'h000A);
      chk(16'(conversion_in_progress), 16'h0000);
      chk(16'(sar_trial_code), 16'(code));
      chk({result_high_byte, result_low_byte},
          want(code, negative_input_select == 5'h1F, left_align_select));
      chk(16'(conversion_done_flag), 16'h0001);
      chk(16'(conversion_irq), 16'(done_irq_enable));
      chk(16'(mux_positive_code), 16'(positive_input_select));
      chk(16'(mux_negative_code), 16'(negative_input_select));
      chk(16'(mux_positive_supply), 16'(positive_input_select == 5'h1F));
      chk(16'(analog_powered), 16'h0001);
      @(posedge clk);
      done_flag_clear <= 1'b1;
      external_convert_start <= 1'b0;
      @(posedge clk);
      done_flag_clear <= 1'b0;
      #1;
      chk(16'(conversion_in_progress), 16'h0000);
      chk(16'(conversion_done_flag), 16'h0000);
    end
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    seed = 32'h0000_2883;
    mismatches = 0;
    num_checks = 0;
    {rst_n, left_align_select, low_power_track_select, busy_write_one} = 4'h0;
    {done_flag_clear, done_irq_enable, timer0_overflow, timer1_overflow} = 4'h0;
    {timer2_low_overflow, timer2_high_overflow, timer2_16bit_mode} = 3'h0;
    {timer3_low_overflow, timer3_high_overflow, timer3_16bit_mode} = 3'h0;
    {external_convert_start, start_source_select, sar_clock_divisor} = 9'h000;
    {positive_input_select, negative_input_select, held_code} = 20'h0_0000;
    converter_enable = 1'b1;
    code = 10'h000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 24; i = i + 1) begin
      r = rnd();
      code = (i > 7) ? r[25:16] : (i[1] ? (i[0] ? 10'h1FF : 10'h200) : (i[0] ? 10'h000 : 10'h3FF));
      @(posedge clk);
      held_code <= code;
      start_source_select <= 3'(i % 6);
      sar_clock_divisor <= (i == 7) ? 5'h1F : {3'h0, r[1:0]};
      low_power_track_select <= i[3];
      {left_align_select, done_irq_enable} <= r[3:2];
      {timer2_16bit_mode, timer3_16bit_mode} <= r[5:4];
      negative_input_select <= i[2] ? 5'h1F : r[11:7];
      positive_input_select <= (i == 4) ? 5'h1D : (i == 5) ? 5'h1F :
                               (i == 6) ? 5'h1E : r[30:26];
      conv(3'(i % 6));
    end
    @(posedge clk);
    start_source_select <= 3'h6;
    fire(3'h6, 1'b0);
    chk(16'(conversion_in_progress), 16'h0000);
    @(posedge clk);
    {start_source_select, low_power_track_select} <= 4'h0;
    sar_clock_divisor <= 5'h03;
    r[15:0] = {result_high_byte, result_low_byte};
    fire(3'h0, 1'b0);
    repeat (12) @(posedge clk);
    converter_enable <= 1'b0;
    @(posedge clk);
    #1;
    chk(16'(conversion_in_progress), 16'h0000);
    chk(16'(conversion_done_flag), 16'h0000);
    chk({result_high_byte, result_low_byte}, r[15:0]);
    chk(16'(analog_powered), 16'h0000);
    @(posedge clk);
    converter_enable <= 1'b1;
    repeat (4) @(posedge clk);
    finish_test;
  end
  initial begin
    repeat (40000) @(posedge clk);
    mismatches = mismatches + 1;
    finish_test;
  end
endmodule
`default_nettype wire
